// File: sink_driver_pkg.sv
package sink_driver_pkg;

   localparam int STAGE_COUNT = 8;
   localparam logic [7:0] STAGE_RESET = 8'h00;
   localparam logic [7:0] DRIVE_OFF = 8'h00;
   localparam logic [1:0] BUF_DEPTH = 2'h2;

   typedef logic [STAGE_COUNT-1:0] stage_word_t;

endpackage

// File: word_link_if.sv
`timescale 1ns/1ns
interface word_link_if;
   import sink_driver_pkg::*;
   stage_word_t data;
   logic valid;
   logic ready;
   modport source (output data, output valid, input ready);
   modport sink (input data, input valid, output ready);
endinterface

// File: word_buffer.sv
`timescale 1ns/1ns
module word_buffer
   import sink_driver_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   word_link_if.sink fill,
   word_link_if.source drain
);

   // ============================================================
   // Two-entry buffer state
   typedef struct packed {
      stage_word_t [1:0] slot;
      logic wr_ptr;
      logic rd_ptr;
      logic [1:0] count;
   } buf_state_t;

   buf_state_t state;
   buf_state_t next_state;
   logic push;
   logic pop;

   assign fill.ready = (state.count != BUF_DEPTH);
   assign drain.valid = (state.count != 2'h0);
   assign drain.data = state.slot[state.rd_ptr];
   assign push = fill.valid && fill.ready;
   assign pop = drain.valid && drain.ready;

   always_comb begin
      next_state = state;
      if (push) begin
         next_state.slot[state.wr_ptr] = fill.data;
         next_state.wr_ptr = ~state.wr_ptr;
      end
      if (pop) begin
         next_state.rd_ptr = ~state.rd_ptr;
      end
      if (push && !pop) begin
         next_state.count = state.count + 2'h1;
      end else if (pop && !push) begin
         next_state.count = state.count - 2'h1;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

endmodule

// File: serial_in_latched_sink_driver.sv
`timescale 1ns/1ns
module serial_in_latched_sink_driver
   import sink_driver_pkg::*;
(
   // System side
   input wire logic sys_clk_in,
   input wire logic resetn_in,

   // Link side, owned by the host
   input wire logic shift_clk_in,
   input wire logic serial_data_in,

   // Control pins, asynchronous to the system clock
   input wire logic latch_load_in,
   input wire logic output_disable_in,

   // Outputs, each straight from a flop
   output logic serial_data_out,
   output logic [STAGE_COUNT-1:0] sink_drive_out,
   output logic word_stall_out
);

   // ============================================================
   // Link domain: shift register on the shift clock
   // No reset here: the shift clock may stand still through reset,
   // so the stages stay unknown until eight bits have gone in.
   stage_word_t shift_stage;

   always_ff @(posedge shift_clk_in) begin
      shift_stage <= {shift_stage[STAGE_COUNT-2:0], serial_data_in};
   end

   // Eighth stage leaves from its own flop, ready for a next device
   assign serial_data_out = shift_stage[STAGE_COUNT-1];

   // ============================================================
   // System domain state
   typedef struct packed {
      // Shift clock seen through two flops plus an edge flop
      logic [2:0] clk_sync;

      // Control pins through two flops each
      logic [1:0] load_sync;
      logic [1:0] dis_sync;

      // Snapshot of the stages, offered to the buffer
      stage_word_t capture;
      logic cap_valid;

      // Newest word that has left the buffer
      stage_word_t staged;

      // Latches and driver flops
      stage_word_t latch;
      stage_word_t drive;

      // Snapshot waiting on a full buffer
      logic stall;
   } sys_state_t;

   sys_state_t state;
   sys_state_t next_state;

   // Decoded views of the synchronised state
   logic shift_seen;
   logic capture_done;
   logic load_open;
   logic outputs_off;
   stage_word_t latch_source;
   stage_word_t drive_gate;

   // ============================================================
   // Word buffer between snapshot and latches
   word_link_if link_fill();
   word_link_if link_drain();

   word_buffer u_buffer (
      .sys_clk_in(sys_clk_in),
      .resetn_in(resetn_in),
      .fill(link_fill.sink),
      .drain(link_drain.source)
   );

   assign link_fill.data = state.capture;
   assign link_fill.valid = state.cap_valid;

   // Latch side takes a word every cycle, so the drain never stalls
   assign link_drain.ready = 1'b1;

   // ============================================================
   // Crossing from the link domain
   // The shift clock itself passes two flops before anything reads it.
   // Its rise is acted on at most 12 ns after the edge, inside the 15 ns
   // shortest shift period, so the stage word is never caught mid-change.
   // Edge flop resets low, the idle level of the shift clock: no false edge.
   assign shift_seen = state.clk_sync[1] && !state.clk_sync[2];

   // Snapshot handed over once the buffer has room
   assign capture_done = state.cap_valid && link_fill.ready;

   // ============================================================
   // Latch and driver control
   assign load_open = state.load_sync[1];
   assign outputs_off = state.dis_sync[1];

   // Open latches follow the newest word, even one just leaving the buffer
   assign latch_source = link_drain.valid ? link_drain.data : state.staged;

   // One gate per driver bit
   for (genvar i = 0; i < STAGE_COUNT; i++) begin : g_drive
      assign drive_gate[i] = outputs_off ? DRIVE_OFF[i] : state.latch[i];
   end

   // ============================================================
   // Next state
   always_comb begin
      next_state = state;

      // Synchronisers
      next_state.clk_sync = {state.clk_sync[1:0], shift_clk_in};
      next_state.load_sync = {state.load_sync[0], latch_load_in};
      next_state.dis_sync = {state.dis_sync[0], output_disable_in};

      // Snapshot: a new edge wins over the hand-over in the same cycle
      if (capture_done) begin
         next_state.cap_valid = 1'b0;
      end
      if (shift_seen) begin
         next_state.capture = shift_stage;
         next_state.cap_valid = 1'b1;
      end
      next_state.stall = state.cap_valid && !link_fill.ready;

      // Remember the newest word for latches opened later
      if (link_drain.valid) begin
         next_state.staged = link_drain.data;
      end

      // Latches follow while load is high, hold while low
      if (load_open) begin
         next_state.latch = latch_source;
      end

      // Drivers show the latches unless disabled
      next_state.drive = drive_gate;
   end

   // ============================================================
   // State register
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // ============================================================
   // Outputs
   assign sink_drive_out = state.drive;
   assign word_stall_out = state.stall;

endmodule

// File: sink_driver_properties.sv
`timescale 1ns/1ns
// ==========
// Port checks
module sink_driver_checker
   import sink_driver_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic shift_clk_in,
   input wire logic serial_data_in,
   input wire logic latch_load_in,
   input wire logic output_disable_in,
   input wire logic serial_data_out,
   input wire logic [STAGE_COUNT-1:0] sink_drive_out,
   input wire logic word_stall_out
);
   logic [7:0] hist;
   logic [7:0] seen;
   // No reset, the stages have none either
   always_ff @(posedge shift_clk_in) begin
      hist <= {hist[6:0], serial_data_in};
      seen <= {seen[6:0], 1'b1};
   end
   a_eight_stage_delay: assert property (@(posedge shift_clk_in) seen[7] |-> serial_data_out == hist[7])
      else $error("serial out lag");
   a_out_on_shift: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      $changed(serial_data_out) |-> $rose(shift_clk_in)) else $error("serial out moved");
   a_reset_drive_off: assert property (@(posedge sys_clk_in) !resetn_in |=> sink_drive_out == DRIVE_OFF)
      else $error("drive on in reset");
   a_disable_forces_off: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      output_disable_in [*5] |-> sink_drive_out == DRIVE_OFF) else $error("drive not off");
   a_latch_holds: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (!latch_load_in && !output_disable_in) [*8] |=> $stable(sink_drive_out)) else $error("drive moved");
   a_no_stall: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) !word_stall_out)
      else $error("word stalled");
endmodule

// File: sink_host_model.sv
`timescale 1ns/1ns
// ==========
// Host side
module sink_host_model (
   output logic shift_clk_out,
   output logic serial_data_out
);
   initial begin
      shift_clk_out = 1'b0;
      serial_data_out = 1'b0;
   end
   // Msb first; clock stands low between words; shared clock chains devices
   task automatic send_word(input logic [7:0] word);
      for (int i = 7; i >= 0; i--) begin
         serial_data_out = word[i];
         #7 shift_clk_out = 1'b1;
         #8 shift_clk_out = 1'b0;
      end
      serial_data_out = ~serial_data_out;
   endtask
endmodule

// File: serial_in_latched_sink_driver_tb.sv
`timescale 1ns/1ns
// ==========
// Bench
module serial_in_latched_sink_driver_tb;
   import sink_driver_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic load = 1'b0;
   logic dis = 1'b0;
   logic sclk, sdi, sdo, stall;
   stage_word_t drive, w;
   logic [31:0] seed = 32'h0000_0012;
   int fails = 0;
   int checked = 0;
   initial forever #2 clk = ~clk;
   sink_host_model host (.shift_clk_out(sclk), .serial_data_out(sdi));
   serial_in_latched_sink_driver dut (.sys_clk_in(clk), .resetn_in(resetn), .shift_clk_in(sclk),
      .serial_data_in(sdi), .latch_load_in(load), .output_disable_in(dis), .serial_data_out(sdo),
      .sink_drive_out(drive), .word_stall_out(stall));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction
   function automatic stage_word_t expect_drive(input stage_word_t v, input logic off);
      return off ? DRIVE_OFF : v;
   endfunction
   task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      cyc(8);
      check("reset drive", drive, DRIVE_OFF);
      resetn = 1'b1;
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         w = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : seed[7:0];
         dis = seed[8] & (i > 1);
         host.send_word(w);
         cyc(10);
         check("serial out", {7'h00, sdo}, {7'h00, w[7]});
         load = 1'b1;
         cyc(5);
         load = 1'b0;
         cyc(6);
         check("drive", drive, expect_drive(w, dis));
         dis = 1'b0;
         cyc(6);
         check("drive kept", drive, w);
         host.send_word(~w);
         cyc(10);
         check("latch hold", drive, w);
         check("chain out", {7'h00, sdo}, {7'h00, ~w[7]});
      end
      // Latch left open with outputs disabled, so drive must stay off while shifting
      dis = 1'b1;
      load = 1'b1;
      host.send_word(8'h5A);
      cyc(10);
      check("open latch off", drive, DRIVE_OFF);
      load = 1'b0;
      cyc(6);
      dis = 1'b0;
      cyc(6);
      check("open latch", drive, 8'h5A);
      check("stall", {7'h00, stall}, 8'h00);
      final_report();
   end
   initial begin
      #20000;
      fails++;
      final_report();
   end
endmodule
bind serial_in_latched_sink_driver sink_driver_checker chk (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
   .shift_clk_in(shift_clk_in), .serial_data_in(serial_data_in), .latch_load_in(latch_load_in),
   .output_disable_in(output_disable_in), .serial_data_out(serial_data_out),
   .sink_drive_out(sink_drive_out), .word_stall_out(word_stall_out));
